// [hdl/nvmp_port.sv]
// Summary of operation
// [R1] command 0x04 selects fuse and lock readout while read drive enable low
// [R2] readout, both byte selects 0: low fuse byte, 0 means programmed
// [R3] readout, both byte selects 1: high fuse byte
// [R4] readout, select two 0 and select one 1: lock bits
// [R5] command 0x08 plus address 0..2: signature byte with select one 0
// [R6] command 0x08 with select one 1: calibration byte
// [R7] busy goes low within 1 us of write strobe falling
// [R8] write commands release busy 3.7 to 4.5 ms after strobe
// [R9] chip erase releases busy 7.5 to 9 ms after strobe
// [R10] read drive enable high: data bus released
// [R11] serial programming only while reset pin held low
// [R12] programming enable first; no program or erase before it
// [R13] serial clock and data in are inputs, data out driven
// [R14] serial eeprom writes carry automatic erase of the location
// [R15] chip erase fills program and eeprom arrays with 0xff
// [R16] programmer holds each clock phase beyond least cpu cycles
// [R17] valid cpu clock present during serial programming
// [R18] action pair 10, select one 0, load strobe pulse loads command
// [R19] action pair 00, select one 0, load strobe pulse loads address low
// [R20] command and address kept until reloaded
// [R21] serial clock synchronised, edges taken after least phase
module nvmp_port
  import nvmp_pkg::*;
#(
  parameter int WRITE_BUSY_CYCLES = WRITE_BUSY_CYC,
  parameter int ERASE_BUSY_CYCLES = ERASE_BUSY_CYC,
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // arbitrary
  parameter logic [7:0] SIG_BYTE2 = 8'h01, // arbitrary
  parameter logic [7:0] CALIB_BYTE = 8'h80
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // parallel programming pins
  input wire logic load_strobe_clock,
  input wire logic [1:0] action_select_pair,
  input wire logic byte_select_one,
  input wire logic byte_select_two,
  input wire logic write_strobe_n,
  input wire logic read_enable_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_flag,
  // serial programming pins
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // requests to the memory arrays
  output logic nvm_write_req,
  output logic nvm_erase_all_req,
  output logic nvm_auto_erase,
  output logic [15:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  // status
  output logic serial_enabled
);

  logic rst_a;
  logic rst_n;
  logic [15:0] pin_a;
  logic [15:0] pin_b;
  logic lsc_d;
  logic wr_d;
  logic [7:0] command;
  logic [15:0] address;
  logic [7:0] data_latch;
  logic [7:0] fuse_low;
  logic [7:0] fuse_high;
  logic [7:0] lock_bits;
  logic [BUSY_CNT_W-1:0] busy_cnt;
  logic sck_level;
  logic sck_rise;
  logic sck_fall;
  logic [31:0] rx_shift;
  logic [7:0] tx_shift;
  logic [4:0] bit_cnt;
  logic ser_done;
  logic [31:0] next_rx;
  logic par_load;
  logic par_write;
  logic ser_erase;
  logic ser_eeprom;
  logic [7:0] next_read;

  // synchronised pin copies
  logic lsc_s, bs1_s, bs2_s, wr_n_s, oe_n_s, prst_n_s, mosi_s;
  logic [1:0] act_s;
  logic [7:0] din_s;
  logic mosi_a;
  logic mosi_q;
  assign {lsc_s, act_s, bs1_s, bs2_s, wr_n_s, oe_n_s, din_s} = {pin_b[15:2], pin_b[0]};
  assign prst_n_s = pin_b[1];
  assign mosi_s = mosi_q;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // two-flop synchronisers on every pin input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a <= PIN_IDLE; // idle levels, so no false strobe or session after reset
      pin_b <= PIN_IDLE;
      mosi_a <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      pin_a <= {load_strobe_clock, action_select_pair, byte_select_one, byte_select_two,
                write_strobe_n, read_enable_n, data_in[7:1], prog_reset_n, data_in[0]};
      pin_b <= pin_a;
      mosi_a <= mosi;
      mosi_q <= mosi_a;
    end
  end

  // edge history of strobes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lsc_d <= 1'b0;
      wr_d <= 1'b1;
    end else begin
      lsc_d <= lsc_s;
      wr_d <= wr_n_s;
    end
  end

  assign par_load = lsc_s & ~lsc_d;
  assign par_write = wr_d & ~wr_n_s & ready_busy_flag;

  // command, address and data latches held until reloaded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      command <= CMD_NOP;
      address <= ADDR_RESET;
      data_latch <= ERASED_BYTE;
    end else if (par_load) begin
      unique case (act_s)
        ACT_CMD: if (!bs1_s) command <= din_s; // [R18] [R20]
        ACT_ADDR: begin
          if (!bs1_s) address[7:0] <= din_s; // [R19] [R20]
          else address[15:8] <= din_s;
        end
        ACT_DATA: data_latch <= din_s;
        default: ;
      endcase
    end
  end

  // fuse and lock storage; chip erase clears lock bits only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_low <= FUSE_LOW_RESET;
      fuse_high <= FUSE_HIGH_RESET;
      lock_bits <= LOCK_RESET;
    end else if (par_write) begin
      if (command == CMD_WRITE_FUSE && !bs2_s) begin
        if (bs1_s) fuse_high <= data_latch;
        else fuse_low <= data_latch;
      end else if (command == CMD_WRITE_LOCK) begin
        lock_bits <= lock_bits & data_latch;
      end else if (command == CMD_CHIP_ERASE) begin
        lock_bits <= ERASED_BYTE;
      end
    end else if (ser_erase) begin
      lock_bits <= ERASED_BYTE;
    end
  end

  // readout byte selection
  always_comb begin
    next_read = ERASED_BYTE;
    if (command == CMD_READ_FUSE_LOCK) begin // [R1]
      if (!bs1_s && !bs2_s) next_read = fuse_low; // [R2]
      else if (bs1_s && bs2_s) next_read = fuse_high; // [R3]
      else if (bs1_s && !bs2_s) next_read = lock_bits; // [R4]
    end else if (command == CMD_READ_SIG_CAL) begin
      if (bs1_s) next_read = CALIB_BYTE; // [R6]
      else if (address[7:0] == 8'h00) next_read = SIG_BYTE0; // [R5]
      else if (address[7:0] == 8'h01) next_read = SIG_BYTE1;
      else if (address[7:0] == SIG_LAST_INDEX) next_read = SIG_BYTE2;
    end
  end

  // data bus drive, released three clock cycles after read enable rises
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= next_read;
      data_oe <= ~oe_n_s & wr_n_s & ((command == CMD_READ_FUSE_LOCK) |
                 (command == CMD_READ_SIG_CAL)); // [R1] [R10]
    end
  end

  // self-timed busy period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= '0;
      ready_busy_flag <= 1'b1;
    end else if (par_write && command == CMD_CHIP_ERASE) begin
      busy_cnt <= BUSY_CNT_W'(ERASE_BUSY_CYCLES); // [R9]
      ready_busy_flag <= 1'b0; // [R7]
    end else if (par_write && (command == CMD_WRITE_FLASH || command == CMD_WRITE_EEPROM ||
                 command == CMD_WRITE_FUSE || command == CMD_WRITE_LOCK)) begin
      busy_cnt <= BUSY_CNT_W'(WRITE_BUSY_CYCLES); // [R8]
      ready_busy_flag <= 1'b0; // [R7]
    end else if (ser_erase && ready_busy_flag) begin
      busy_cnt <= BUSY_CNT_W'(ERASE_BUSY_CYCLES);
      ready_busy_flag <= 1'b0;
    end else if (ser_eeprom && ready_busy_flag) begin
      busy_cnt <= BUSY_CNT_W'(WRITE_BUSY_CYCLES);
      ready_busy_flag <= 1'b0;
    end else if (busy_cnt > BUSY_CNT_W'(1)) begin
      busy_cnt <= busy_cnt - 1'b1;
    end else begin
      busy_cnt <= '0;
      ready_busy_flag <= 1'b1;
    end
  end

  // serial clock filter
  nvmp_sck_filter u_sck (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sck_pin(sck), // [R13]
    .sck_level(sck_level),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall)
  );

  assign next_rx = {rx_shift[30:0], mosi_s};
  assign ser_done = sck_rise & ~prst_n_s & (bit_cnt == SER_LAST_BIT);
  assign ser_erase = ser_done & serial_enabled & (next_rx[31:24] == SER_PREFIX) &
                     (next_rx[23:21] == SER_ERASE_B2); // [R12]
  assign ser_eeprom = ser_done & serial_enabled & (next_rx[31:24] == SER_WRITE_EEPROM); // [R12]

  // serial shift in on rising edges, echo out on falling edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= '0;
      tx_shift <= 8'h00;
      bit_cnt <= '0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else if (prst_n_s) begin
      bit_cnt <= '0; // [R11]
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1; // [R13]
      if (sck_rise) begin
        rx_shift <= next_rx;
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt[2:0] == 3'h7) tx_shift <= next_rx[7:0];
        else tx_shift <= {tx_shift[6:0], 1'b0};
      end
      if (sck_fall) miso <= tx_shift[7];
    end
  end

  // programming enable state, lost when reset pin rises
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_enabled <= 1'b0;
    end else if (prst_n_s) begin
      serial_enabled <= 1'b0; // [R11]
    end else if (ser_done && next_rx[31:24] == SER_PREFIX &&
                 next_rx[23:16] == SER_ENABLE_B2) begin
      serial_enabled <= 1'b1; // [R12]
    end
  end

  // requests to the arrays
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_write_req <= 1'b0;
      nvm_erase_all_req <= 1'b0;
      nvm_auto_erase <= 1'b0;
      nvm_addr <= ADDR_RESET;
      nvm_wdata <= ERASED_BYTE;
    end else begin
      nvm_write_req <= 1'b0;
      nvm_erase_all_req <= 1'b0;
      if (ser_erase || (par_write && command == CMD_CHIP_ERASE)) begin
        nvm_erase_all_req <= 1'b1;
        nvm_wdata <= ERASED_BYTE; // [R15]
        nvm_auto_erase <= 1'b0;
      end else if (ser_eeprom && ready_busy_flag) begin
        nvm_write_req <= 1'b1;
        nvm_auto_erase <= 1'b1; // [R14]
        nvm_addr <= {7'h00, next_rx[16:8]};
        nvm_wdata <= next_rx[7:0];
      end else if (par_write && (command == CMD_WRITE_FLASH ||
                   command == CMD_WRITE_EEPROM)) begin
        nvm_write_req <= 1'b1;
        nvm_auto_erase <= 1'b0;
        nvm_addr <= address;
        nvm_wdata <= data_latch;
      end
    end
  end

endmodule : nvmp_port

// [hdl/nvmp_pkg.sv]
package nvmp_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 8;
  // parallel command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
  localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
  localparam logic [7:0] CMD_READ_SIG_CAL = 8'h08;
  localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  // action select pair codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  // serial instruction bytes
  localparam logic [7:0] SER_PREFIX = 8'hac;
  localparam logic [7:0] SER_ENABLE_B2 = 8'h53;
  localparam logic [2:0] SER_ERASE_B2 = 3'h4;
  localparam logic [7:0] SER_WRITE_EEPROM = 8'hc0;
  localparam logic [4:0] SER_LAST_BIT = 5'h1f;
  // erased content and reset values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] FUSE_LOW_RESET = 8'he1;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'hd9;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] PIN_IDLE = 16'h0602; // synchroniser reset: write strobe, read enable and reset pin high, load strobe low
  // signature index range
  localparam logic [7:0] SIG_LAST_INDEX = 8'h02;
  // busy timing in ns, and derived least cycle counts (rounded up)
  localparam int T_WRITE_MIN_NS = 3700000;
  localparam int T_WRITE_MAX_NS = 4500000;
  localparam int T_ERASE_MIN_NS = 7500000;
  localparam int T_ERASE_MAX_NS = 9000000;
  localparam int T_BUSY_LOW_MAX_NS = 1000;
  localparam int WRITE_BUSY_CYC = (T_WRITE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_BUSY_CYC = (T_ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W = 21;
  // serial clock least phase, cpu clock at or above 12 MHz
  localparam int SCK_MIN_PHASE_CYC = 3;
  localparam int SCK_CNT_W = 3;
endpackage : nvmp_pkg

// [hdl/nvmp_sck_filter.sv]
module nvmp_sck_filter
  import nvmp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw serial clock pin
  input wire logic sck_pin,
  // filtered level and edge pulses
  output logic sck_level,
  output logic sck_rise,
  output logic sck_fall
);

  logic sync_a;
  logic sync_b;
  logic [SCK_CNT_W-1:0] stable_cnt;

  // two-stage synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= sck_pin;
      sync_b <= sync_a;
    end
  end

  // a new level is accepted only once it has stood for the least phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_cnt <= '0;
      sck_level <= 1'b0;
      sck_rise <= 1'b0;
      sck_fall <= 1'b0;
    end else begin
      sck_rise <= 1'b0;
      sck_fall <= 1'b0;
      if (sync_b == sck_level) begin
        stable_cnt <= '0;
      end else if (stable_cnt == SCK_CNT_W'(SCK_MIN_PHASE_CYC - 1)) begin
        stable_cnt <= '0; // [R21]
        sck_level <= sync_b;
        sck_rise <= sync_b;
        sck_fall <= ~sync_b;
      end else begin
        stable_cnt <= stable_cnt + 1'b1;
      end
    end
  end

endmodule : nvmp_sck_filter

// [test/nvmp_port_checker.sv]
module nvmp_port_checker
  import nvmp_pkg::*;
#(
  parameter int WRITE_BUSY_CYCLES = WRITE_BUSY_CYC,
  parameter int ERASE_BUSY_CYCLES = ERASE_BUSY_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // watched pins
  input wire logic write_strobe_n,
  input wire logic read_enable_n,
  input wire logic prog_reset_n,
  input wire logic data_oe,
  input wire logic ready_busy_flag,
  input wire logic miso_oe,
  input wire logic nvm_write_req,
  input wire logic nvm_erase_all_req,
  input wire logic nvm_auto_erase,
  input wire logic serial_enabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  localparam int WR_MAX = WRITE_BUSY_CYCLES * 45 / 37 + 4;
  localparam int ER_MAX = ERASE_BUSY_CYCLES * 6 / 5 + 4;
  int busy_cnt;
  int wr_age;
  logic wr_q;
  logic erasing;
  // length of the current busy period
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) busy_cnt <= 0;
    else if (ready_busy_flag) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  // cycles since the write strobe fell, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b1;
      wr_age <= 200;
    end else begin
      wr_q <= write_strobe_n;
      if (wr_q && !write_strobe_n) wr_age <= 0;
      else if (wr_age < 200) wr_age <= wr_age + 1;
    end
  end
  // marks a busy period that belongs to a chip erase
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) erasing <= 1'b0;
    else if (nvm_erase_all_req) erasing <= 1'b1;
    else if (ready_busy_flag) erasing <= 1'b0;
  end
  sequence s_read_off;
    read_enable_n [*5];
  endsequence
  sequence s_pin_low;
    !prog_reset_n [*4];
  endsequence
  sequence s_pin_high;
    prog_reset_n [*4];
  endsequence
  a_busy_len_ok: assert property ($rose(ready_busy_flag) |-> (erasing ?
    (busy_cnt >= ERASE_BUSY_CYCLES - 3 && busy_cnt <= ER_MAX) :
    (busy_cnt >= WRITE_BUSY_CYCLES - 3 && busy_cnt <= WR_MAX)))
    else $error("busy period length out of range");
  a_busy_start_fast: assert property ($fell(ready_busy_flag) |-> wr_age <= 125 || !prog_reset_n)
    else $error("busy fell without a recent write strobe");
  a_erase_in_busy: assert property (nvm_erase_all_req |-> ##[0:2] !ready_busy_flag)
    else $error("erase request outside busy");
  a_req_one_cycle: assert property (nvm_write_req || nvm_erase_all_req |=>
    !nvm_write_req && !nvm_erase_all_req)
    else $error("array request longer than one cycle");
  a_bus_release: assert property (s_read_off |-> !data_oe)
    else $error("data bus still driven");
  a_oe_cause: assert property (data_oe |-> !$past(read_enable_n, 3))
    else $error("data bus driven without read enable");
  a_miso_drive: assert property (s_pin_low |-> miso_oe)
    else $error("serial out not driven in session");
  a_enable_drop: assert property (s_pin_high |-> !serial_enabled && !miso_oe)
    else $error("serial state kept with reset pin high");
  a_serial_gate: assert property ((nvm_write_req || nvm_erase_all_req) && !prog_reset_n
    |-> serial_enabled)
    else $error("serial request before enable");
  a_auto_erase: assert property (nvm_write_req && !prog_reset_n |-> nvm_auto_erase)
    else $error("serial write without auto erase");
endmodule : nvmp_port_checker

bind nvmp_port nvmp_port_checker #(
  .WRITE_BUSY_CYCLES(WRITE_BUSY_CYCLES),
  .ERASE_BUSY_CYCLES(ERASE_BUSY_CYCLES)
) nvmp_port_checker_inst (
  .sys_clk(sys_clk), .nrst(nrst), .write_strobe_n(write_strobe_n),
  .read_enable_n(read_enable_n), .prog_reset_n(prog_reset_n), .data_oe(data_oe),
  .ready_busy_flag(ready_busy_flag), .miso_oe(miso_oe), .nvm_write_req(nvm_write_req),
  .nvm_erase_all_req(nvm_erase_all_req), .nvm_auto_erase(nvm_auto_erase),
  .serial_enabled(serial_enabled)
);

// [test/nvmp_prog_model.sv]
module nvmp_prog_model (
  // clock and readback
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  input wire logic miso,
  // parallel pins
  output logic load_strobe_clock,
  output logic [1:0] action_select_pair,
  output logic byte_select_one,
  output logic byte_select_two,
  output logic write_strobe_n,
  output logic read_enable_n,
  output logic [7:0] data_in,
  // serial pins
  output logic prog_reset_n,
  output logic sck,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  // serial out bits seen during the last frame
  logic [31:0] so;
  // idle pin levels
  initial begin
    {load_strobe_clock, action_select_pair, byte_select_one, byte_select_two} = '0;
    {write_strobe_n, read_enable_n, prog_reset_n, data_in, sck, mosi} = 13'h1c00;
  end
  // step to just after a rising edge
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // strobe 160 ns high, 208 ns low, setup 72 ns, hold 208 ns after the strobe falls
  task load(input logic [1:0] act, input logic b1, input logic [7:0] d);
    action_select_pair = act;
    byte_select_one = b1;
    data_in = d;
    tick(9);
    load_strobe_clock = 1'b1;
    tick(20);
    load_strobe_clock = 1'b0;
    tick(26);
    data_in = ~d; // released bus shows no stale value
  endtask : load
  // write strobe low for 160 ns
  task wr(input logic b1, input logic b2);
    byte_select_one = b1;
    byte_select_two = b2;
    tick(9);
    write_strobe_n = 1'b0;
    tick(20);
    write_strobe_n = 1'b1;
  endtask : wr
  // read enable low, sample after the readout latency
  task rd(input logic b1, input logic b2, output logic [7:0] d);
    byte_select_one = b1;
    byte_select_two = b2;
    read_enable_n = 1'b0;
    tick(6);
    d = data_out;
    read_enable_n = 1'b1;
    tick(6);
  endtask : rd
  // 32 bits msb first, 40 ns phases, clock parked low between frames
  task ser(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      tick(5);
      sck = 1'b1;
      tick(5);
      so = {so[30:0], miso}; // taken late in the high phase, after the synchronised update
      sck = 1'b0;
    end
    mosi = ~w[0];
    tick(10);
  endtask : ser
  // reset pin low opens a serial session
  task session(input logic on);
    prog_reset_n = ~on;
    tick(10);
  endtask : session
endmodule : nvmp_prog_model

// [test/nvmp_port_bench.sv]
module nvmp_port_bench
  import nvmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WB = 40;
  localparam int EB = 80;
  localparam logic [7:0] CAL = 8'h6b; // arbitrary
  localparam logic [7:0] SIG [3] = '{8'h4b, 8'h27, 8'hc5}; // arbitrary
  localparam logic [7:0] WCMD [4] = '{CMD_WRITE_FLASH, CMD_WRITE_EEPROM, CMD_WRITE_FUSE,
    CMD_WRITE_LOCK};
  // pins and bench state
  logic sys_clk, nrst, lsc, bs1, bs2, wr_n, rd_n, prn, sck, mosi, miso, miso_oe, oe, rdy;
  logic wreq, ereq, auto, sen, cap_auto;
  logic [1:0] act;
  logic [7:0] din, dout, wdata, d, ad, lk, ed, cap_data;
  logic [8:0] ea;
  logic [15:0] addr, cap_addr;
  int err_total, comparisons, wr_cnt, er_cnt, c0, n;
  nvmp_port #(.WRITE_BUSY_CYCLES(WB), .ERASE_BUSY_CYCLES(EB), .SIG_BYTE0(SIG[0]),
    .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CALIB_BYTE(CAL)) nvmp_port_inst (
    .sys_clk(sys_clk), .nrst(nrst), .load_strobe_clock(lsc), .action_select_pair(act),
    .byte_select_one(bs1), .byte_select_two(bs2), .write_strobe_n(wr_n),
    .read_enable_n(rd_n), .data_in(din), .data_out(dout), .data_oe(oe),
    .ready_busy_flag(rdy), .prog_reset_n(prn), .sck(sck), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .nvm_write_req(wreq), .nvm_erase_all_req(ereq),
    .nvm_auto_erase(auto), .nvm_addr(addr), .nvm_wdata(wdata), .serial_enabled(sen));
  nvmp_prog_model prog (.sys_clk(sys_clk), .data_out(dout), .load_strobe_clock(lsc),
    .action_select_pair(act), .byte_select_one(bs1), .byte_select_two(bs2),
    .write_strobe_n(wr_n), .read_enable_n(rd_n), .data_in(din), .prog_reset_n(prn),
    .sck(sck), .mosi(mosi), .miso(miso));
  // cpu clock, always running during serial work
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end
  // count and capture array requests, away from the launching edge
  always @(negedge sys_clk) begin
    if (ereq === 1'b1) er_cnt++;
    if (wreq === 1'b1) begin
      wr_cnt++;
      {cap_auto, cap_addr, cap_data} = {auto, addr, wdata};
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] sig_exp(input logic [7:0] a);
    return (a <= SIG_LAST_INDEX) ? SIG[a[1:0]] : ERASED_BYTE;
  endfunction : sig_exp
  // wait for ready and check the time since the strobe fell
  task busy(input int len);
    n = 20; // the write task returns 20 cycles after the strobe fell
    chk(rdy, 16'h0000);
    while (rdy !== 1'b1 && n < 3 * len) begin
      prog.tick(1);
      n++;
    end
    chk(16'(n >= len && n <= len * 6 / 5 + 4), 16'h0001);
  endtask : busy
  // fuse low, fuse high and lock readout
  task rd_fl(input logic [7:0] lock);
    prog.rd(1'b0, 1'b0, d);
    chk(d, FUSE_LOW_RESET);
    prog.rd(1'b1, 1'b1, d);
    chk(d, FUSE_HIGH_RESET);
    prog.rd(1'b1, 1'b0, d);
    chk(d, lock);
    chk(oe, 16'h0000);
  endtask : rd_fl
  task wait_rdy;
    for (int i = 0; i < 4 * EB && rdy !== 1'b1; i++) prog.tick(1);
  endtask : wait_rdy
  task finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200us;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    void'($urandom(5));
    lk = 8'($urandom());
    repeat (8) @(posedge sys_clk);
    #1 nrst = 1'b1;
    prog.tick(6);
    chk({rdy, oe, sen, miso_oe}, 16'h0008);
    foreach (WCMD[i]) begin
      prog.load(ACT_CMD, 1'b0, WCMD[i]);
      prog.load(ACT_DATA, 1'b0, WCMD[i] == CMD_WRITE_FUSE ? FUSE_LOW_RESET : lk);
      prog.wr(1'b0, 1'b0);
      busy(WB);
    end
    chk({7'h00, cap_auto, cap_data}, {7'h00, 1'b0, lk});
    chk(cap_addr, ADDR_RESET);
    prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE_LOCK);
    prog.load(ACT_CMD, 1'b1, CMD_NOP);
    rd_fl(lk);
    prog.load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
    prog.wr(1'b0, 1'b0);
    busy(EB);
    chk(16'(er_cnt), 16'h0001);
    prog.load(ACT_CMD, 1'b0, CMD_READ_FUSE_LOCK);
    rd_fl(ERASED_BYTE);
    prog.load(ACT_CMD, 1'b0, CMD_READ_SIG_CAL);
    for (int a = 0; a < 4; a++) begin
      ad = (a == 3) ? 8'($urandom_range(255, 3)) : 8'(a);
      prog.load(ACT_ADDR, 1'b0, ad);
      prog.rd(1'b0, 1'b0, d);
      chk(d, sig_exp(ad));
      prog.rd(1'b1, 1'b0, d);
      chk(d, CAL);
    end
    c0 = wr_cnt;
    ea = 9'($urandom());
    ed = 8'($urandom());
    prog.session(1'b1);
    chk(miso_oe, 16'h0001);
    prog.ser({SER_PREFIX, SER_ERASE_B2, 21'h0_0000});
    prog.ser({SER_WRITE_EEPROM, 7'h00, ea, ed});
    chk({er_cnt[7:0], 8'(wr_cnt - c0)}, 16'h0100);
    prog.ser({SER_PREFIX, SER_ENABLE_B2, 16'h0000});
    chk(sen, 16'h0001);
    chk(prog.so[15:8], SER_ENABLE_B2);
    prog.ser({SER_WRITE_EEPROM, 7'h00, ea, ed});
    chk(16'(wr_cnt - c0), 16'h0001);
    chk(cap_addr, {7'h00, ea});
    chk({7'h00, cap_auto, cap_data}, {7'h00, 1'b1, ed});
    wait_rdy();
    prog.ser({SER_PREFIX, SER_ERASE_B2, 21'h0_0000});
    chk(16'(er_cnt), 16'h0002);
    wait_rdy();
    prog.session(1'b0);
    chk({sen, miso_oe}, 16'h0000);
    prog.ser({SER_PREFIX, SER_ENABLE_B2, 16'h0000});
    chk(sen, 16'h0000);
    finish_test();
  end
endmodule : nvmp_port_bench
